// ===== verilog/dfta_regs.svh
`ifndef DFTA_REGS_SVH
`define DFTA_REGS_SVH

// Software register offsets (byte addresses, one word each)
`define DFTA_OFS_SELECT 8'h00
`define DFTA_OFS_CMD 8'h04
`define DFTA_OFS_STATUS 8'h08
`define DFTA_OFS_ATTN 8'h0c
`define DFTA_OFS_CYL 8'h10
`define DFTA_OFS_HEAD 8'h14
`define DFTA_OFS_CTRL 8'h18

// Field positions, host words numbered with bit 0 as least significant
`define DFTA_DRVNUM_LSB 0
`define DFTA_ARG_LSB 0
`define DFTA_KIND_LSB 8
`define DFTA_HEAD_LSB 0
`define DFTA_CTRL_FSEEK_BIT 0
`define DFTA_CTRL_DIAG_BIT 1
`define DFTA_SELRD_LINES_LSB 16
`define DFTA_ATTN_COMB_BIT 9
`define DFTA_CTRL_BUSY_BIT 0
`define DFTA_CTRL_HOLD_BIT 1
`define DFTA_CTRL_DIAGACT_BIT 2
`define DFTA_CTRL_INDEX_LSB 8

// Reset values
`define DFTA_RST_DRVNUM 4'h0
`define DFTA_RST_SELECT 9'h001

// Control tag command words, argument bit 7 drives unit bus line 0
`define DFTA_CMD_RESET_HEAD 8'h10
`define DFTA_CMD_DIAG_RESET 8'h50

// Unit S is the last drive number
`define DFTA_UNIT_S 4'h8

// Timing
`define DFTA_CLK_PERIOD_NS 8
`define DFTA_PHASES 5
`define DFTA_GATE_NS 3000
`define DFTA_DIAG_HOLD_NS 25000000

`endif

// ===== verilog/dfta_pkg.sv
package dfta_pkg;

  // Command sequencer states, one-hot
  typedef enum logic [4:0] {
    DFTA_ST_IDLE = 5'b00001,
    DFTA_ST_WAIT = 5'b00010,
    DFTA_ST_GATE = 5'b00100,
    DFTA_ST_DIAG = 5'b01000,
    DFTA_ST_NEXT = 5'b10000
  } dfta_state_e;

  // Which tag line qualifies the unit bus
  typedef enum logic [1:0] {
    DFTA_TAG_CONTROL = 2'h0,
    DFTA_TAG_CYL = 2'h1,
    DFTA_TAG_HEAD = 2'h2,
    DFTA_TAG_NONE = 2'h3
  } dfta_tag_e;

endpackage

// ===== verilog/dfta_timer.sv
`timescale 1ns/1ps
module dfta_timer #(
  parameter int unsigned WIDTH = 22,
  parameter int unsigned COUNT = 375
) (
  // Clock and control
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clr,
  // Start and state
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [WIDTH-1:0] count_q;

  // Load on start, run down to zero; a new start restarts the window
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_q <= '0;
    end else if (ce) begin
      if (clr) begin
        count_q <= '0;
      end else if (start) begin
        count_q <= WIDTH'(COUNT);
      end else if (count_q != '0) begin
        count_q <= count_q - WIDTH'(1);
      end
    end
  end

  assign busy = (count_q != '0);
  // Last counted cycle, so the owner can close the window on the same edge
  assign done = ce && !clr && !start && (count_q == WIDTH'(1));
endmodule

// ===== verilog/dfta_decoder.sv
`timescale 1ns/1ps
module dfta_decoder #(
  parameter int unsigned UNITS = 9
) (
  // Drive number in, one select line out
  input wire logic [3:0] number,
  output logic [UNITS-1:0] lines
);
  // Numbers past the last drive select nothing
  always_comb begin
    lines = '0;
    for (int i = 0; i < UNITS; i++) begin
      if (number == 4'(i)) begin
        lines[i] = 1'b1;
      end
    end
  end
endmodule

// ===== verilog/dfta_host.sv
`timescale 1ns/1ps
`include "dfta_regs.svh"
module dfta_host
  import dfta_pkg::*;
#(
  parameter int unsigned UNITS = 9,
  parameter int unsigned DIAG_CYCLES =
    (`DFTA_DIAG_HOLD_NS + `DFTA_CLK_PERIOD_NS - 1) / `DFTA_CLK_PERIOD_NS
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic master_clear_signal,
  // Software register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Lines toward the drives
  output logic [7:0] unit_bus,
  output logic control_tag,
  output logic set_cyl_tag,
  output logic set_head_tag,
  output logic [UNITS-1:0] select_unit,
  output logic bus_gate_pulse,
  // Lines from the drives
  input wire logic [7:0] cyl_lines,
  input wire logic [UNITS-1:0] attention,
  input wire logic [7:0] status_lines,
  input wire logic selected_index,
  input wire logic [UNITS-1:0] unit_selected,
  // Combined attention toward the processor
  output logic combined_attention
);
  import dfta_pkg::*;

  localparam int unsigned GATE_CYCLES =
    (`DFTA_GATE_NS + `DFTA_CLK_PERIOD_NS - 1) / `DFTA_CLK_PERIOD_NS;
  localparam int unsigned PH_W = 3;

  dfta_state_e state_q;
  dfta_tag_e kind_q;
  logic [PH_W-1:0] phase_q;
  logic [3:0] drvnum_q;
  logic sel_pend_q;
  logic [UNITS-1:0] select_q;
  logic [UNITS-1:0] decoded;
  logic [7:0] arg_q;
  logic head_pend_q;
  logic [4:0] head_val_q;
  logic diag_q;
  logic [7:0] unit_bus_q;
  logic [2:0] tag_q;
  logic hold_q;
  logic [7:0] status_q;
  logic [7:0] cyl_q;
  logic index_d1_q;
  logic [7:0] index_cnt_q;
  logic [31:0] rdata_q;
  logic [7:0] bus_word;
  logic wr_sel;
  logic wr_cmd;
  logic wr_head;
  logic wr_ctrl;
  logic clear;
  logic at_t00;
  logic at_t20;
  logic launch;
  logic gate_start;
  logic diag_start;
  logic gate_busy;
  logic gate_done;
  logic diag_busy;
  logic diag_done;
  logic idle;

  // Write decode; commands arriving while busy are dropped
  assign idle = (state_q == DFTA_ST_IDLE);
  assign wr_sel = wr && (addr == `DFTA_OFS_SELECT);
  assign wr_cmd = wr && (addr == `DFTA_OFS_CMD) && idle;
  assign wr_head = wr && (addr == `DFTA_OFS_HEAD) && idle;
  assign wr_ctrl = wr && (addr == `DFTA_OFS_CTRL) && idle;
  // Master clear and each select write clear the adapter logic
  assign clear = master_clear_signal || wr_sel;

  // Shared-resources clock phases, one per enabled cycle: T00 is 0, T20 is 1
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= '0;
    end else if (ce) begin
      if (phase_q == PH_W'(`DFTA_PHASES - 1)) begin
        phase_q <= '0;
      end else begin
        phase_q <= phase_q + PH_W'(1);
      end
    end
  end
  assign at_t00 = (phase_q == PH_W'(0));
  assign at_t20 = (phase_q == PH_W'(1));

  // Drive number register, low nibble of the host word
  always_ff @(posedge mclk) begin
    if (rst || master_clear_signal) begin
      drvnum_q <= `DFTA_RST_DRVNUM;
      sel_pend_q <= 1'b0;
    end else if (ce) begin
      if (wr_sel) begin
        drvnum_q <= wdata[`DFTA_DRVNUM_LSB +: 4];
        sel_pend_q <= 1'b1;
      end else if (at_t20) begin
        sel_pend_q <= 1'b0;
      end
    end
  end

  dfta_decoder #(
    .UNITS(UNITS)
  ) u_decoder (
    .number(drvnum_q),
    .lines(decoded)
  );

  // Select lines move only at phase 20; unit S drops after its command
  always_ff @(posedge mclk) begin
    if (rst || master_clear_signal) begin
      select_q <= UNITS'(`DFTA_RST_SELECT);
    end else if (ce) begin
      if (sel_pend_q && !wr_sel && at_t20) begin
        select_q <= decoded;
      end else if ((gate_done || diag_done) && drvnum_q == `DFTA_UNIT_S) begin
        select_q <= '0;
      end
    end
  end
  assign select_unit = select_q;

  // Command sequencer: wait for T00, then hold the tag for the gate window
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= DFTA_ST_IDLE;
    end else if (ce) begin
      if (clear) begin
        state_q <= DFTA_ST_IDLE;
      end else begin
        case (state_q)
          DFTA_ST_IDLE: begin
            if (wr_cmd || wr_head || (wr_ctrl && wdata[`DFTA_CTRL_DIAG_BIT])) begin
              state_q <= DFTA_ST_WAIT;
            end
          end
          DFTA_ST_WAIT: begin
            if (at_t00 && !sel_pend_q) begin
              state_q <= diag_q ? DFTA_ST_DIAG : DFTA_ST_GATE;
            end
          end
          DFTA_ST_GATE: begin
            if (gate_done) begin
              state_q <= head_pend_q ? DFTA_ST_NEXT : DFTA_ST_IDLE;
            end
          end
          DFTA_ST_DIAG: begin
            if (diag_done) begin
              state_q <= DFTA_ST_IDLE;
            end
          end
          DFTA_ST_NEXT: begin
            state_q <= DFTA_ST_WAIT;
          end
          default: begin
            state_q <= DFTA_ST_IDLE;
          end
        endcase
      end
    end
  end
  assign launch = ce && !clear && (state_q == DFTA_ST_WAIT) && at_t00 && !sel_pend_q;
  assign gate_start = launch && !diag_q;
  assign diag_start = launch && diag_q;

  // Argument and tag kind; a head write is split into two commands
  always_ff @(posedge mclk) begin
    if (rst) begin
      arg_q <= 8'h00;
      kind_q <= DFTA_TAG_NONE;
      head_pend_q <= 1'b0;
      head_val_q <= 5'h00;
      diag_q <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        head_pend_q <= 1'b0;
        diag_q <= 1'b0;
      end else if (wr_cmd) begin
        arg_q <= wdata[`DFTA_ARG_LSB +: 8];
        kind_q <= dfta_tag_e'(wdata[`DFTA_KIND_LSB +: 2]);
      end else if (wr_head) begin
        arg_q <= `DFTA_CMD_RESET_HEAD;
        kind_q <= DFTA_TAG_CONTROL;
        head_pend_q <= 1'b1;
        head_val_q <= wdata[`DFTA_HEAD_LSB +: 5];
      end else if (wr_ctrl && wdata[`DFTA_CTRL_DIAG_BIT]) begin
        arg_q <= `DFTA_CMD_DIAG_RESET;
        kind_q <= DFTA_TAG_CONTROL;
        diag_q <= 1'b1;
      end else if (state_q == DFTA_ST_NEXT) begin
        arg_q <= {3'h0, head_val_q};
        kind_q <= DFTA_TAG_HEAD;
        head_pend_q <= 1'b0;
      end else if (diag_done) begin
        diag_q <= 1'b0;
      end
    end
  end

  // Argument bit 7 goes to bus line 0, line 7 carries weight 1
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_word[i] = arg_q[7 - i];
    end
  end

  dfta_timer #(
    .WIDTH(9),
    .COUNT(GATE_CYCLES)
  ) u_gate (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clr(clear),
    .start(gate_start),
    .busy(gate_busy),
    .done(gate_done)
  );

  dfta_timer #(
    .WIDTH(32),
    .COUNT(DIAG_CYCLES)
  ) u_diag (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clr(clear),
    .start(diag_start),
    .busy(diag_busy),
    .done(diag_done)
  );

  assign bus_gate_pulse = gate_busy || diag_busy;

  // Bus and one tag are loaded together and dropped together
  always_ff @(posedge mclk) begin
    if (rst) begin
      unit_bus_q <= 8'h00;
      tag_q <= 3'h0;
    end else if (ce) begin
      if (clear || gate_done || diag_done) begin
        unit_bus_q <= 8'h00;
        tag_q <= 3'h0;
      end else if (launch) begin
        unit_bus_q <= bus_word;
        case (kind_q)
          DFTA_TAG_CONTROL: tag_q <= 3'h1;
          DFTA_TAG_CYL: tag_q <= 3'h2;
          DFTA_TAG_HEAD: tag_q <= 3'h4;
          default: tag_q <= 3'h0;
        endcase
      end
    end
  end
  assign unit_bus = unit_bus_q;
  assign control_tag = tag_q[0];
  assign set_cyl_tag = tag_q[1];
  assign set_head_tag = tag_q[2];

  // First-seek hold; a request in the same cycle as a new start leaves it set
  always_ff @(posedge mclk) begin
    if (rst || master_clear_signal) begin
      hold_q <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl && wdata[`DFTA_CTRL_FSEEK_BIT]) begin
        hold_q <= 1'b1;
      end else if (wr && addr == `DFTA_OFS_ATTN) begin
        hold_q <= 1'b0;
      end
    end
  end

  // Unit S stays out of the combined attention
  assign combined_attention = !hold_q && (|attention[UNITS-2:0]);

  // Request status and request cylinder snapshot the drive lines
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_q <= 8'h00;
      cyl_q <= 8'h00;
    end else if (ce) begin
      if (wr && addr == `DFTA_OFS_STATUS) begin
        status_q <= status_lines;
      end
      if (wr && addr == `DFTA_OFS_CYL) begin
        cyl_q <= cyl_lines;
      end
    end
  end

  // Index marks counted on the rising edge, wraps freely
  always_ff @(posedge mclk) begin
    if (rst) begin
      index_d1_q <= 1'b0;
      index_cnt_q <= 8'h00;
    end else if (ce) begin
      index_d1_q <= selected_index;
      if (selected_index && !index_d1_q) begin
        index_cnt_q <= index_cnt_q + 8'h01;
      end
    end
  end

  // Read data one cycle after the strobe, zero for unmapped offsets
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 32'h0;
    end else if (ce) begin
      rdata_q <= 32'h0;
      if (rd) begin
        case (addr)
          `DFTA_OFS_SELECT: begin
            rdata_q[3:0] <= drvnum_q;
            rdata_q[`DFTA_SELRD_LINES_LSB +: UNITS] <= unit_selected;
          end
          `DFTA_OFS_STATUS: rdata_q[7:0] <= status_q;
          `DFTA_OFS_ATTN: begin
            rdata_q[UNITS-1:0] <= attention;
            rdata_q[`DFTA_ATTN_COMB_BIT] <= combined_attention;
          end
          `DFTA_OFS_CYL: rdata_q[7:0] <= cyl_q;
          `DFTA_OFS_CTRL: begin
            rdata_q[`DFTA_CTRL_BUSY_BIT] <= !idle;
            rdata_q[`DFTA_CTRL_HOLD_BIT] <= hold_q;
            rdata_q[`DFTA_CTRL_DIAGACT_BIT] <= diag_busy;
            rdata_q[`DFTA_CTRL_INDEX_LSB +: 8] <= index_cnt_q;
          end
          default: rdata_q <= 32'h0;
        endcase
      end
    end
  end
  assign rdata = rdata_q;
endmodule

// ===== testbench/dfta_host_monitor.sv
`timescale 1ns/1ps
`include "dfta_regs.svh"
module dfta_host_monitor #(
  parameter int unsigned UNITS = 9,
  parameter int unsigned DIAG_CYCLES = 40
) (
  // Clock, reset, clear
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic master_clear_signal,
  // Software port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  // Drive side
  input wire logic [7:0] unit_bus,
  input wire logic control_tag,
  input wire logic set_cyl_tag,
  input wire logic set_head_tag,
  input wire logic [UNITS-1:0] select_unit,
  input wire logic bus_gate_pulse,
  input wire logic [UNITS-1:0] attention,
  input wire logic combined_attention
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic any_tag;
  logic [31:0] gate_cnt_q;
  logic head_ok_q;
  logic [8:0] sel_want_q;
  assign any_tag = control_tag | set_cyl_tag | set_head_tag;
  // Gate length in enabled cycles; read at the fall, so it holds the full high count
  always_ff @(posedge mclk) begin
    if (rst || !bus_gate_pulse) begin
      gate_cnt_q <= 32'h0;
    end else if (ce) begin
      gate_cnt_q <= gate_cnt_q + 32'h1;
    end
  end
  // A head reset command arms the next head load
  always_ff @(posedge mclk) begin
    if (rst) begin
      head_ok_q <= 1'b0;
    end else if (control_tag && unit_bus == 8'h08) begin
      head_ok_q <= 1'b1;
    end else if (set_head_tag) begin
      head_ok_q <= 1'b0;
    end
  end
  // Selection asked for by the last select write
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_want_q <= 9'h001;
    end else if (ce && wr && addr == `DFTA_OFS_SELECT) begin
      sel_want_q <= 9'h001 << wdata[3:0];
    end
  end
  AST_ONE_TAG: assert property ($onehot0({control_tag, set_cyl_tag, set_head_tag}))
    else $error("more than one tag high");
  AST_BUS_STABLE: assert property (any_tag && $past(any_tag) |-> $stable(unit_bus))
    else $error("unit bus moved under a tag");
  AST_TAG_GATED: assert property (any_tag |-> bus_gate_pulse)
    else $error("tag without gate");
  AST_TAG_START: assert property ($rose(any_tag) |-> $rose(bus_gate_pulse))
    else $error("gate did not start with tag");
  AST_GATE_LEN: assert property ($fell(bus_gate_pulse) |->
    gate_cnt_q == 32'd375 || gate_cnt_q == DIAG_CYCLES)
    else $error("gate length wrong");
  AST_DIAG_BUS: assert property ($fell(bus_gate_pulse) && gate_cnt_q == DIAG_CYCLES |->
    $past(unit_bus) == 8'h0a)
    else $error("diagnostic lines wrong");
  AST_SEL_ONEHOT: assert property ($onehot0(select_unit))
    else $error("more than one select line");
  AST_MC_SEL: assert property (master_clear_signal |=> select_unit == 9'h001)
    else $error("master clear did not pick drive 0");
  AST_SEL_FOLLOW: assert property (ce && wr && addr == `DFTA_OFS_SELECT |->
    ##[1:10] select_unit == sel_want_q)
    else $error("selection did not follow write");
  AST_ATTN_OR: assert property (combined_attention |-> (|attention[7:0]))
    else $error("combined attention without a source");
  AST_HEAD_ORDER: assert property ($rose(set_head_tag) |-> head_ok_q)
    else $error("head load without head reset");
  cover property ($rose(set_head_tag));
  cover property ($rose(set_cyl_tag));
  cover property ($fell(bus_gate_pulse) && gate_cnt_q == DIAG_CYCLES);
endmodule
bind dfta_host dfta_host_monitor #(.UNITS(UNITS), .DIAG_CYCLES(DIAG_CYCLES)) dfta_host_monitor_inst (
  .mclk(mclk), .rst(rst), .ce(ce), .master_clear_signal(master_clear_signal),
  .addr(addr), .wdata(wdata), .wr(wr), .unit_bus(unit_bus), .control_tag(control_tag),
  .set_cyl_tag(set_cyl_tag), .set_head_tag(set_head_tag), .select_unit(select_unit),
  .bus_gate_pulse(bus_gate_pulse), .attention(attention),
  .combined_attention(combined_attention));

// ===== testbench/dfta_drives.sv
`timescale 1ns/1ps
module dfta_drives #(
  parameter int unsigned IDX_PER = 200,
  parameter int unsigned IDX_HI = 20
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // From the controller
  input wire logic [7:0] unit_bus,
  input wire logic control_tag,
  input wire logic set_cyl_tag,
  input wire logic set_head_tag,
  input wire logic [8:0] select_unit,
  input wire logic bus_gate_pulse,
  // To the controller
  output logic [7:0] cyl_lines,
  output logic [8:0] attention,
  output logic [7:0] status_lines,
  output logic selected_index,
  output logic [8:0] unit_selected
);
  logic [7:0] cyl_q, pos_q, junk_q, rb;
  logic [4:0] head_q;
  logic valid_q, ctl_q;
  logic [15:0] idx_q;
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction
  // Line 0 carries the top weight
  assign rb = rev8(unit_bus);
  assign unit_selected = select_unit;
  assign cyl_lines = valid_q ? pos_q : junk_q;
  assign status_lines = {3'h0, head_q};
  assign selected_index = (|select_unit) && idx_q < IDX_HI;
  // Head register ORs loads, so a missing head reset shows up
  always @(posedge mclk) begin
    junk_q <= junk_q + 8'h5b;
    ctl_q <= control_tag;
    idx_q <= (idx_q == IDX_PER - 1) ? 16'h0 : idx_q + 16'h1;
    if (rst) begin
      valid_q <= 1'b0;
      head_q <= 5'h0;
      attention <= 9'h0;
      junk_q <= 8'h3c;
      idx_q <= 16'h0;
    end else if (control_tag && bus_gate_pulse && !ctl_q) begin
      if (unit_bus[3]) head_q <= 5'h0;
      if (unit_bus[2]) begin
        pos_q <= cyl_q;
        valid_q <= 1'b1;
        attention <= attention | select_unit;
      end
      if (unit_bus[1]) attention <= attention & ~select_unit;
    end else if (set_cyl_tag && bus_gate_pulse) begin
      cyl_q <= rb;
      valid_q <= 1'b0;
    end else if (set_head_tag && bus_gate_pulse) begin
      head_q <= head_q | rb[4:0];
    end
  end
endmodule

// ===== testbench/dfta_host_test.sv
`timescale 1ns/1ps
`include "dfta_regs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dfta_host_test;
  import dfta_pkg::*;
  localparam int unsigned DIAG = 40;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, master_clear_signal = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rd_was = 1'b0;
  logic [7:0] addr = 8'h0, unit_bus, cyl_lines, status_lines;
  logic [31:0] wdata = 32'h0, rdata, wlen = 32'h0;
  logic control_tag, set_cyl_tag, set_head_tag, bus_gate_pulse;
  logic selected_index, combined_attention;
  logic [8:0] select_unit, attention, unit_selected;
  logic [9:0] wgot;
  logic [41:0] we;
  logic [63:0] re;
  logic [41:0] wq[$];
  logic [63:0] rq[$];
  int fails = 0, checked = 0;
  dfta_host #(.DIAG_CYCLES(DIAG)) dfta_host_inst (.mclk, .rst, .ce, .master_clear_signal,
    .addr, .wdata, .wr, .rd, .rdata, .unit_bus, .control_tag, .set_cyl_tag, .set_head_tag,
    .select_unit, .bus_gate_pulse, .cyl_lines, .attention, .status_lines, .selected_index,
    .unit_selected, .combined_attention);
  dfta_drives dfta_drives_inst (.mclk, .rst, .unit_bus, .control_tag, .set_cyl_tag,
    .set_head_tag, .select_unit, .bus_gate_pulse, .cyl_lines, .attention, .status_lines,
    .selected_index, .unit_selected);
  always #4 mclk = ~mclk;
  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev8[i] = v[7 - i];
  endfunction
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Expected word is noted before the strobe goes out
  task automatic rreg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({m, e});
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 9000 && (wq.size() != 0 || rq.size() != 0); n++) @(posedge mclk);
    if (n == 9000) begin
      fails++;
      wrap_up();
    end
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic cmd(input logic [1:0] t, input logic [7:0] a);
    wq.push_back({t, rev8(a), 32'd375});
    wreg(`DFTA_OFS_CMD, {22'h0, t, a});
    drain();
  endtask
  task automatic sel(input logic [3:0] d);
    int n;
    wreg(`DFTA_OFS_SELECT, {28'h0, d});
    for (n = 0; n < 20 && select_unit !== 9'h001 << d; n++) @(negedge mclk);
    `CHK(select_unit, 9'h001 << d)
  endtask
  // Watcher: settled values at the falling edge
  always @(negedge mclk) begin
    if (rd_was) begin
      re = rq.pop_front();
      `CHK(rdata & re[63:32], re[31:0])
    end
    rd_was = rd;
    if (control_tag | set_cyl_tag | set_head_tag) begin
      if (wlen == 0) wgot = {set_head_tag, set_cyl_tag, unit_bus};
      wlen++;
    end else if (wlen != 0) begin
      we = (wq.size() != 0) ? wq.pop_front() : 42'h0;
      `CHK({wgot, wlen}, we)
      wlen = 0;
    end
  end
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    wrap_up();
  end
  initial begin
    logic [7:0] v;
    logic [3:0] d;
    void'($urandom(34));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({select_unit, control_tag, set_cyl_tag, set_head_tag}, 12'h008)
    for (int i = 0; i < 9; i++) begin
      sel(i[3:0]);
      rreg(`DFTA_OFS_SELECT, {7'h0, 9'h001 << i, 12'h0, i[3:0]}, 32'h01ff000f);
    end
    sel(4'h5);
    @(posedge mclk);
    master_clear_signal <= 1'b1;
    @(posedge mclk);
    master_clear_signal <= 1'b0;
    @(negedge mclk);
    `CHK(select_unit, 9'h001)
    wreg(8'h40, 32'hffffffff);
    rreg(8'h40, 32'h0, 32'hffffffff);
    drain();
    $display("test select done");
    for (int k = 7; k >= 0; k--) cmd(2'h0, 8'h80 >> k);
    d = 4'($urandom % 8);
    v = 8'($urandom);
    sel(d);
    cmd(2'h1, v);
    cmd(2'h0, 8'h20);
    wreg(`DFTA_OFS_CYL, 32'h0);
    rreg(`DFTA_OFS_CYL, {24'h0, v}, 32'hff);
    rreg(`DFTA_OFS_ATTN, 32'h200 | 32'h1 << d, 32'h3ff);
    cmd(2'h0, 8'h40);
    rreg(`DFTA_OFS_ATTN, 32'h0, 32'h3ff);
    drain();
    $display("test seek done");
    for (int j = 0; j < 2; j++) begin
      v = {3'h0, 5'($urandom)};
      wq.push_back({2'h0, 8'h08, 32'd375});
      wq.push_back({2'h2, rev8(v), 32'd375});
      wreg(`DFTA_OFS_HEAD, {24'h0, v});
      drain();
      wreg(`DFTA_OFS_STATUS, 32'h0);
      rreg(`DFTA_OFS_STATUS, {24'h0, v}, 32'hff);
      drain();
    end
    $display("test head done");
    sel(4'h8);
    cmd(2'h0, 8'h20);
    `CHK({select_unit, combined_attention}, 10'h000)
    rreg(`DFTA_OFS_ATTN, 32'h100, 32'h3ff);
    sel(4'h2);
    wreg(`DFTA_OFS_CTRL, 32'h1);
    rreg(`DFTA_OFS_CTRL, 32'h2, 32'h7);
    cmd(2'h0, 8'h20);
    `CHK(combined_attention, 1'b0)
    wreg(`DFTA_OFS_ATTN, 32'h0);
    @(negedge mclk);
    `CHK(combined_attention, 1'b1)
    cmd(2'h0, 8'h40);
    $display("test attention done");
    // Gate-only command: busy with no tag, then idle again
    wreg(`DFTA_OFS_CMD, 32'h3ff);
    rreg(`DFTA_OFS_CTRL, 32'h1, 32'h7);
    repeat (400) @(posedge mclk);
    rreg(`DFTA_OFS_CTRL, 32'h0, 32'h7);
    // Five frozen cycles stretch the diagnostic hold by five
    wq.push_back({2'h0, 8'h0a, DIAG + 32'd5});
    wreg(`DFTA_OFS_CTRL, 32'h2);
    for (int n = 0; n < 50 && !control_tag; n++) @(negedge mclk);
    @(posedge mclk);
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    rreg(`DFTA_OFS_CTRL, 32'h5, 32'h7);
    drain();
    $display("test diagnostic done");
    wrap_up();
  end
endmodule
